// ==== rtl/dbf_consts.vh ====
`ifndef DBF_CONSTS_VH
`define DBF_CONSTS_VH
// Clock rate and timing figures
`define DBF_CLK_HZ          25000000
`define DBF_SS_TIME_US      1000
`define DBF_SS_CYC          ((`DBF_SS_TIME_US * (`DBF_CLK_HZ / 1000000)))
`define DBF_US_GAP_MS       40
`define DBF_US_GAP_CYC      ((`DBF_US_GAP_MS * (`DBF_CLK_HZ / 1000)))
`define DBF_GATE_DLY_NS     40
`define DBF_GATE_DLY_CYC    (((`DBF_GATE_DLY_NS + 39) / 40))
`define DBF_OCS_TIME_US     10
`define DBF_OCS_CYC         ((`DBF_OCS_TIME_US * (`DBF_CLK_HZ / 1000000)))
// Width of the soft-start reference ramp
`define DBF_RAMP_W          10
// Supply-good drive codes
`define DBF_PG_HIZ          2'h0
`define DBF_PG_UPPER        2'h1
`define DBF_PG_LOWER        2'h2
`endif

// ==== rtl/dbf_sequencer.v ====
// Notes on behaviour
// - Each start ramps an internal reference from zero to full over about 1 ms.
// - Under-voltage or shutdown starts soft-stop, closing the output discharge switch.
// - Reference stays active during soft-stop so over-voltage monitoring continues.
// - Current reversal turns low-side off; very light load skips pulses.
// - In ultrasonic mode, 40 ms without switching issues an ultrasonic pulse.
// - Pulse: low-side on, comp high then high-side, comp again low-side to zero-cross.
// - Ultrasonic keeps switching at or above 25 Hz, else ordinary pulse frequency.
// - Pulling a comp/shutdown input low stops only that channel.
// - Released comp/shutdown input starts fresh initialization then soft-start.
// - Supply-good encodes faulting channel: upper 100 ohm path, lower 60 ohm path.
// - Over-voltage, under-voltage and over-current on either channel are faults.
// - Supply-good released only when both feedbacks above 90% and both normal.
// - Low-side turn-off: wait gate below 1.5 V, then high-side after fixed delay.
// - High-side turn-off: wait gate crossing 1.5 V, then low-side after delay.
// - Over-temperature shuts both channels down and latches them off.
// - Latched shutdowns persist until power cycle or both shutdown inputs toggle.
// - Before soft-start, source current into limit resistor, hold voltage, stop source.
// - Low-side voltage above held limit shuts converter, latching both channels off.
// - Under-voltage watched only after soft-start; below 70% starts soft-stop.
// - Under-voltage on either channel latches both off once soft-stop ends.
// - Over 120% holds low-side on until below 5%, then all off, gates low.
`include "dbf_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module dbf_sequencer #(
  parameter integer SS_CYCLES   = `DBF_SS_CYC,
  parameter integer GAP_CYCLES  = `DBF_US_GAP_CYC,
  parameter integer OCS_CYCLES  = `DBF_OCS_CYC,
  parameter integer GDLY_CYCLES = `DBF_GATE_DLY_CYC
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire [1:0] comp_shutdown_input,
  input  wire       ultrasonic_en,
  input  wire [1:0] pwm_request,
  input  wire [1:0] current_reverse,
  input  wire [1:0] skip_request,
  input  wire [1:0] comp_above_045,
  input  wire [1:0] low_gate_below_15,
  input  wire [1:0] high_gate_off_15,
  input  wire [1:0] fb_above_90,
  input  wire [1:0] fb_below_70,
  input  wire [1:0] fb_above_120,
  input  wire [1:0] out_below_5,
  input  wire [1:0] sense_over_limit,
  input  wire       over_temp,
  output reg  [1:0] high_side_gate,
  output reg  [1:0] low_side_gate,
  output reg  [1:0] discharge_on,
  output reg  [1:0] current_limit_source,
  output reg  [1:0] limit_hold,
  output reg  [1:0] ref_active,
  output reg  [`DBF_RAMP_W*2-1:0] ref_ramp,
  output reg  [1:0] supply_good_code
);
  // Channel states
  localparam [2:0] ST_OFF   = 3'h0;
  localparam [2:0] ST_OCSET = 3'h1;
  localparam [2:0] ST_SOFT  = 3'h2;
  localparam [2:0] ST_RUN   = 3'h3;
  localparam [2:0] ST_STOP  = 3'h4;
  localparam [2:0] ST_OVDIS = 3'h5;
  localparam [2:0] ST_LATCH = 3'h6;
  // Ultrasonic pulse phases
  localparam [1:0] UP_IDLE = 2'h0;
  localparam [1:0] UP_LOW1 = 2'h1;
  localparam [1:0] UP_HIGH = 2'h2;
  localparam [1:0] UP_LOW2 = 2'h3;
  localparam [`DBF_RAMP_W-1:0] RAMP_FULL = {`DBF_RAMP_W{1'b1}};

  // Two-stage synchronizers for all analog comparator inputs
  localparam integer NS = 26;
  wire [NS-1:0] raw_in = {comp_shutdown_input, pwm_request, current_reverse, skip_request,
                          comp_above_045, low_gate_below_15, high_gate_off_15, fb_above_90,
                          fb_below_70, fb_above_120, out_below_5, sense_over_limit,
                          over_temp, ultrasonic_en};
  reg  [NS-1:0] meta_q;
  reg  [NS-1:0] sync_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {NS{1'b0}};
      sync_q <= {NS{1'b0}};
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end
  wire [1:0] s_en   = sync_q[25:24];
  wire [1:0] s_pwm  = sync_q[23:22];
  wire [1:0] s_rev  = sync_q[21:20];
  wire [1:0] s_skip = sync_q[19:18];
  wire [1:0] s_comp = sync_q[17:16];
  wire [1:0] s_lgl  = sync_q[15:14];
  wire [1:0] s_hgl  = sync_q[13:12];
  wire [1:0] s_f90  = sync_q[11:10];
  wire [1:0] s_f70  = sync_q[9:8];
  wire [1:0] s_f120 = sync_q[7:6];
  wire [1:0] s_o5   = sync_q[5:4];
  wire [1:0] s_oc   = sync_q[3:2];
  wire       s_ot   = sync_q[1];
  wire       s_us   = sync_q[0];

  // Shared latch: any protection trip turns both channels off
  reg        prot_latch_q;
  reg  [1:0] en_prev_q;
  reg  [1:0] toggled_q;
  reg  [1:0] fault_q;
  wire [1:0] en_fall = ~s_en & en_prev_q;
  wire [1:0] ov_done;
  wire [1:0] uv_done;
  wire [1:0] trip_now;
  // Toggle tracking releases the latch only after both inputs cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prot_latch_q <= 1'b0;
      en_prev_q    <= 2'b00;
      toggled_q    <= 2'b00;
    end else begin
      en_prev_q <= s_en;
      if (s_ot || (|trip_now) || (|uv_done) || (|ov_done)) begin
        prot_latch_q <= 1'b1;
        toggled_q    <= 2'b00;
      end else if (prot_latch_q) begin
        toggled_q <= toggled_q | en_fall;
        if (&(toggled_q | en_fall) && (&s_en)) begin
          prot_latch_q <= 1'b0;
          toggled_q    <= 2'b00;
        end
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      reg [2:0]  st_q;
      reg [1:0]  up_q;
      reg        uv_q;
      reg [22:0] cnt_q;
      reg [20:0] gap_q;
      reg [7:0]  gd_q;
      reg        want_hi_q;
      reg        want_lo_q;
      wire       run   = (st_q == ST_RUN);
      wire [31:0] ramp_calc = cnt_q * RAMP_FULL / SS_CYCLES; // Ramp point, cut below
      // OC, UV and OV trips; OV handled by low-side discharge first
      assign trip_now[c] = (run || st_q == ST_SOFT) && s_oc[c] && low_side_gate[c];
      assign uv_done[c]  = (st_q == ST_STOP) && uv_q && (cnt_q >= SS_CYCLES - 1);
      assign ov_done[c]  = (st_q == ST_OVDIS) && s_o5[c];

      // Channel sequencing state machine
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          st_q  <= ST_OFF;
          uv_q  <= 1'b0;
          cnt_q <= 23'h00_0000;
          fault_q[c] <= 1'b0;
          ref_ramp[c*`DBF_RAMP_W +: `DBF_RAMP_W] <= {`DBF_RAMP_W{1'b0}};
        end else begin
          case (st_q)
            ST_OFF: begin
              cnt_q <= 23'h00_0000;
              fault_q[c] <= 1'b0;
              ref_ramp[c*`DBF_RAMP_W +: `DBF_RAMP_W] <= {`DBF_RAMP_W{1'b0}};
              if (s_en[c] && !prot_latch_q && !s_ot)
                st_q <= ST_OCSET;
            end
            ST_OCSET: begin
              cnt_q <= cnt_q + 23'h00_0001;
              if (cnt_q >= OCS_CYCLES - 1) begin
                cnt_q <= 23'h00_0000;
                st_q  <= ST_SOFT;
              end
            end
            ST_SOFT: begin
              cnt_q <= cnt_q + 23'h00_0001;
              ref_ramp[c*`DBF_RAMP_W +: `DBF_RAMP_W] <=
                ramp_calc[`DBF_RAMP_W-1:0];
              if (cnt_q >= SS_CYCLES - 1) begin
                ref_ramp[c*`DBF_RAMP_W +: `DBF_RAMP_W] <= RAMP_FULL;
                st_q <= ST_RUN;
              end
            end
            ST_RUN: begin
              if (s_f70[c]) begin
                uv_q  <= 1'b1;
                fault_q[c] <= 1'b1;
                cnt_q <= 23'h00_0000;
                st_q  <= ST_STOP;
              end
            end
            ST_STOP: begin
              cnt_q <= cnt_q + 23'h00_0001;
              if (cnt_q >= SS_CYCLES - 1) begin
                st_q <= uv_q ? ST_LATCH : ST_OFF;
                uv_q <= 1'b0;
              end
            end
            ST_OVDIS: begin
              if (s_o5[c])
                st_q <= ST_LATCH;
            end
            ST_LATCH: begin
              if (!prot_latch_q)
                st_q <= ST_OFF;
            end
            default: st_q <= ST_OFF;
          endcase
          // Overrides in priority order
          if (st_q != ST_OFF && st_q != ST_LATCH && st_q != ST_OVDIS) begin
            if (|s_f120) begin
              fault_q[c] <= s_f120[c];
              st_q <= ST_OVDIS;
            end else if (s_ot || trip_now[c] || (prot_latch_q && st_q != ST_STOP)) begin
              fault_q[c] <= fault_q[c] | trip_now[c];
              st_q <= ST_LATCH;
            end else if (!s_en[c] && st_q != ST_STOP) begin
              cnt_q <= 23'h00_0000;
              st_q  <= ST_STOP;
            end
          end
        end
      end

      // Ultrasonic gap timer and pulse sequence
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          gap_q <= 21'h00_0000;
          up_q  <= UP_IDLE;
        end else if (!run || !s_us) begin
          gap_q <= 21'h00_0000;
          up_q  <= UP_IDLE;
        end else begin
          case (up_q)
            UP_IDLE: begin
              if (s_pwm[c]) begin
                gap_q <= 21'h00_0000;
              end else if (gap_q >= GAP_CYCLES - 1) begin
                gap_q <= 21'h00_0000;
                up_q  <= UP_LOW1;
              end else begin
                gap_q <= gap_q + 21'h00_0001;
              end
            end
            UP_LOW1: if (s_comp[c]) up_q <= UP_HIGH;
            UP_HIGH: if (s_comp[c]) up_q <= UP_LOW2;
            UP_LOW2: if (s_rev[c]) up_q <= UP_IDLE;
            default: up_q <= UP_IDLE;
          endcase
        end
      end

      // Requested gate levels per mode
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          want_hi_q <= 1'b0;
          want_lo_q <= 1'b0;
        end else begin
          want_hi_q <= 1'b0;
          want_lo_q <= 1'b0;
          if (st_q == ST_OVDIS) begin
            want_lo_q <= 1'b1;
          end else if ((run || st_q == ST_SOFT) && up_q != UP_IDLE) begin
            want_hi_q <= (up_q == UP_HIGH);
            want_lo_q <= (up_q != UP_HIGH);
          end else if ((run || st_q == ST_SOFT) && !s_skip[c]) begin
            want_hi_q <= s_pwm[c];
            want_lo_q <= !s_pwm[c] && !s_rev[c];
          end
        end
      end

      // Break-before-make gate driver with fixed release delay
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          high_side_gate[c] <= 1'b0;
          low_side_gate[c]  <= 1'b0;
          gd_q <= 8'h00;
        end else if (st_q == ST_LATCH || st_q == ST_OFF) begin
          high_side_gate[c] <= 1'b0;
          low_side_gate[c]  <= 1'b0;
          gd_q <= 8'h00;
        end else begin
          if (!want_hi_q) high_side_gate[c] <= 1'b0;
          if (!want_lo_q) low_side_gate[c]  <= 1'b0;
          if (want_hi_q && !high_side_gate[c]) begin
            if (!low_side_gate[c] && s_lgl[c]) begin
              gd_q <= gd_q + 8'h01;
              if (gd_q >= GDLY_CYCLES - 1) begin
                high_side_gate[c] <= 1'b1;
                gd_q <= 8'h00;
              end
            end else gd_q <= 8'h00;
          end else if (want_lo_q && !low_side_gate[c]) begin
            if (!high_side_gate[c] && s_hgl[c]) begin
              gd_q <= gd_q + 8'h01;
              if (gd_q >= GDLY_CYCLES - 1) begin
                low_side_gate[c] <= 1'b1;
                gd_q <= 8'h00;
              end
            end else gd_q <= 8'h00;
          end else gd_q <= 8'h00;
        end
      end

      // Discharge, limit sourcing and reference outputs
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          discharge_on[c]         <= 1'b0;
          current_limit_source[c] <= 1'b0;
          limit_hold[c]           <= 1'b0;
          ref_active[c]           <= 1'b0;
        end else begin
          discharge_on[c]         <= (st_q == ST_STOP);
          current_limit_source[c] <= (st_q == ST_OCSET) && (cnt_q < OCS_CYCLES - 2);
          limit_hold[c]           <= (st_q == ST_OCSET && cnt_q >= OCS_CYCLES - 2) ||
                                     limit_hold[c] && st_q != ST_OFF;
          ref_active[c]           <= (st_q != ST_OFF && st_q != ST_LATCH);
        end
      end
    end
  endgenerate

  // Encoded supply-good drive
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_good_code <= `DBF_PG_UPPER;
    end else if (fault_q[1]) begin
      supply_good_code <= `DBF_PG_UPPER;
    end else if (fault_q[0]) begin
      supply_good_code <= `DBF_PG_LOWER;
    end else if (g_ch[1].st_q != ST_RUN) begin
      supply_good_code <= `DBF_PG_UPPER;
    end else if (g_ch[0].st_q != ST_RUN) begin
      supply_good_code <= `DBF_PG_LOWER;
    end else if (&s_f90) begin
      supply_good_code <= `DBF_PG_HIZ;
    end else begin
      supply_good_code <= s_f90[1] ? `DBF_PG_LOWER : `DBF_PG_UPPER;
    end
  end
endmodule
`default_nettype wire

// ==== sim/dbf_stage_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbf_stage_model (
  input  wire logic           clk,
  input  wire logic [1:0]     high_side_gate,
  input  wire logic [1:0]     low_side_gate,
  output var  logic [1:0]     low_gate_below_15 = 2'h3,
  output var  logic [1:0]     high_gate_off_15 = 2'h3,
  output var  logic [1:0]     comp_above_045 = 2'h0,
  output var  logic [1:0]     current_reverse = 2'h0
);
  logic [3:0] phase_q = 4'h0;
  // Gate monitors lag the commands by a cycle, like a slow driver
  always @(posedge clk) begin
    phase_q <= phase_q + 4'h1;
    low_gate_below_15 <= ~low_side_gate;
    high_gate_off_15 <= ~high_side_gate;
    comp_above_045 <= {2{phase_q[2]}};
    current_reverse <= low_side_gate & {2{phase_q[3]}};
  end
endmodule
`default_nettype wire

// ==== sim/dbf_seq_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module dbf_seq_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [1:0] comp_shutdown_input,
  input wire logic [1:0] fb_above_90,
  input wire logic       over_temp,
  input wire logic [1:0] high_side_gate,
  input wire logic [1:0] low_side_gate,
  input wire logic [1:0] discharge_on,
  input wire logic [1:0] current_limit_source,
  input wire logic [1:0] limit_hold,
  input wire logic [1:0] ref_active,
  input wire logic [1:0] supply_good_code
);
  logic [2:0] sd_cnt_q;
  logic [2:0] fb_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Saturating counts of shutdown low and feedback not good
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sd_cnt_q <= 3'h0;
      fb_cnt_q <= 3'h0;
    end else begin
      sd_cnt_q <= comp_shutdown_input[0] ? 3'h0 : (sd_cnt_q == 3'h5 ? 3'h5 : sd_cnt_q + 3'h1);
      fb_cnt_q <= (fb_above_90 == 2'h3) ? 3'h0 : (fb_cnt_q == 3'h5 ? 3'h5 : fb_cnt_q + 3'h1);
    end
  end
  reset_state_a: assert property (disable iff (1'b0) !resetn |=> supply_good_code == 2'h1
    && high_side_gate == 2'h0 && low_side_gate == 2'h0) else $error("reset state wrong");
  no_overlap_a: assert property ((high_side_gate & low_side_gate) == 2'h0)
    else $error("both gates on");
  code_legal_a: assert property (supply_good_code != 2'h3) else $error("bad good code");
  good_needs_fb_a: assert property (fb_cnt_q == 3'h5 |-> supply_good_code != 2'h0)
    else $error("good while feedback low");
  ch_shutdown_a: assert property (sd_cnt_q == 3'h5 |-> !high_side_gate[0])
    else $error("high gate on in shutdown");
  hot_off_a: assert property ($rose(over_temp) |-> ##[1:8] (high_side_gate == 2'h0
    && low_side_gate == 2'h0)) else $error("over temperature not off");
  src_gate_off_a: assert property (current_limit_source[1] |-> !low_side_gate[1]
    && !high_side_gate[1]) else $error("gate on while sourcing");
  hold_after_a: assert property ($fell(current_limit_source[0]) |-> ##[0:1] limit_hold[0])
    else $error("limit not held");
  stop_ref_a: assert property ((discharge_on & ~ref_active) == 2'h0)
    else $error("reference off in soft-stop");
  cover property ($rose(limit_hold[0]));
  cover property (supply_good_code == 2'h2);
  cover property ($rose(over_temp));
endmodule
bind dbf_sequencer dbf_seq_chk u_chk (.clk(clk), .resetn(resetn),
  .comp_shutdown_input(comp_shutdown_input), .fb_above_90(fb_above_90), .over_temp(over_temp),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate), .discharge_on(discharge_on),
  .current_limit_source(current_limit_source), .limit_hold(limit_hold),
  .ref_active(ref_active), .supply_good_code(supply_good_code));
`default_nettype wire

// ==== sim/dbf_sequencer_tb.sv ====
`include "dbf_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module dbf_sequencer_tb;
  logic clk, resetn, ultrasonic_en, over_temp;
  logic [1:0] comp_shutdown_input, pwm_request, fb_above_90, fb_below_70, fb_above_120;
  logic [1:0] out_below_5, sense_over_limit, lgb, hgo, c045, crev;
  logic [1:0] high_side_gate, low_side_gate, discharge_on, current_limit_source, limit_hold;
  logic [1:0] ref_active, supply_good_code, skip_request;
  logic [`DBF_RAMP_W*2-1:0] ref_ramp;
  logic [9:0] r0;
  logic [3:0] rows [4] = '{4'b1010, 4'b0101, 4'b0001, 4'b1100};
  int num_errors = 0;
  int total_checks = 0;
  int i, k;
  dbf_sequencer #(.SS_CYCLES(50), .GAP_CYCLES(100), .OCS_CYCLES(8), .GDLY_CYCLES(1)) u_dut (
    .clk(clk), .resetn(resetn), .comp_shutdown_input(comp_shutdown_input),
    .ultrasonic_en(ultrasonic_en), .pwm_request(pwm_request), .current_reverse(crev),
    .skip_request(skip_request), .comp_above_045(c045), .low_gate_below_15(lgb),
    .high_gate_off_15(hgo), .fb_above_90(fb_above_90), .fb_below_70(fb_below_70),
    .fb_above_120(fb_above_120), .out_below_5(out_below_5), .sense_over_limit(sense_over_limit),
    .over_temp(over_temp), .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .discharge_on(discharge_on), .current_limit_source(current_limit_source),
    .limit_hold(limit_hold), .ref_active(ref_active), .ref_ramp(ref_ramp),
    .supply_good_code(supply_good_code));
  dbf_stage_model u_stage (.clk(clk), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .low_gate_below_15(lgb), .high_gate_off_15(hgo),
    .comp_above_045(c045), .current_reverse(crev));
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Both shutdown inputs low then high, then a full start
  task automatic up();
    comp_shutdown_input <= 2'h0;
    cyc(6);
    comp_shutdown_input <= 2'h3;
    cyc(80);
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    cyc(5000);
    num_errors++;
    test_done();
  end
  // Main sequence
  initial begin
    resetn = 1'b0; ultrasonic_en = 1'b0; over_temp = 1'b0; comp_shutdown_input = 2'h0;
    pwm_request = 2'h0; fb_above_90 = 2'h0; fb_below_70 = 2'h0; fb_above_120 = 2'h0;
    out_below_5 = 2'h0; sense_over_limit = 2'h0; skip_request = 2'h0;
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    chk(supply_good_code, 2'h1);
    chk({high_side_gate, low_side_gate, ref_active}, 6'h00);
    comp_shutdown_input <= 2'h3;
    for (k = 0; k < 10 && current_limit_source !== 2'h3; k++) cyc(1);
    chk(current_limit_source, 2'h3);
    chk(low_side_gate, 2'h0);
    cyc(33);
    r0 = ref_ramp[9:0];
    cyc(10);
    chk(ref_ramp[9:0] > r0, 1'b1);
    cyc(40);
    chk(ref_active, 2'h3);
    chk(ref_ramp, 20'hf_ffff);
    pwm_request <= 2'h3;
    for (i = 0; i < 4; i++) begin
      fb_above_90 <= rows[i][3:2];
      cyc(6);
      chk(supply_good_code, rows[i][1:0]);
    end
    comp_shutdown_input <= 2'h2;
    cyc(6);
    chk(discharge_on[0], 1'b1);
    chk(ref_active, 2'h3);
    cyc(60);
    comp_shutdown_input <= 2'h3;
    cyc(6);
    chk(current_limit_source[0], 1'b1);
    cyc(80);
    pwm_request <= 2'h0;
    ultrasonic_en <= 1'b1;
    skip_request <= 2'h3;
    cyc(20);
    chk({high_side_gate[1], low_side_gate[1]}, 2'h0);
    for (k = 0; k < 150 && low_side_gate[1] !== 1'b1; k++) cyc(1);
    chk(k > 70, 1'b1);
    chk({low_side_gate[1], high_side_gate[1]}, 2'h2);
    ultrasonic_en <= 1'b0;
    skip_request <= 2'h0;
    pwm_request <= 2'h3;
    cyc(20);
    fb_above_120 <= 2'h2;
    cyc(12);
    chk(low_side_gate, 2'h3);
    chk(supply_good_code, 2'h1);
    out_below_5 <= 2'h3;
    fb_above_120 <= 2'h0;
    cyc(20);
    chk({high_side_gate, low_side_gate}, 4'h0);
    out_below_5 <= 2'h0;
    up();
    chk(ref_active, 2'h3);
    sense_over_limit <= 2'h1;
    pwm_request <= 2'h0;
    cyc(20);
    chk({high_side_gate, low_side_gate}, 4'h0);
    chk(supply_good_code, 2'h2);
    sense_over_limit <= 2'h0;
    comp_shutdown_input <= 2'h2;
    cyc(6);
    comp_shutdown_input <= 2'h3;
    cyc(20);
    chk({current_limit_source, high_side_gate, low_side_gate}, 6'h00);
    up();
    fb_below_70 <= 2'h2;
    cyc(6);
    chk(discharge_on[1], 1'b1);
    fb_below_70 <= 2'h0;
    cyc(70);
    chk({high_side_gate, low_side_gate}, 4'h0);
    up();
    over_temp <= 1'b1;
    cyc(8);
    over_temp <= 1'b0;
    cyc(10);
    chk({high_side_gate, low_side_gate}, 4'h0);
    up();
    chk(ref_active, 2'h3);
    resetn <= 1'b0;
    cyc(2);
    chk(supply_good_code, 2'h1);
    test_done();
  end
endmodule
`default_nettype wire
